// *** verification/imbf_core_model.sv ***
// imbf_core_model.sv: far-side core, reports its mode and partition
// assumes the bench steers mode changes on the shared core clock
`timescale 1ns/1ps
`include "imbf_consts.svh"
module imbf_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go_guest,
  input wire logic [`IMBF_PID_W-1:0] go_pid,
  output logic core_guest_mode_flag,
  output logic [`IMBF_PID_W-1:0] core_partition_id
);
  // mode is reported every cycle, never left floating
  always_ff @(posedge clk) begin
    if (rst) begin
      core_guest_mode_flag <= 1'h0;
      core_partition_id <= 3'h0;
    end else begin
      core_guest_mode_flag <= go_guest;
      core_partition_id <= go_pid;
    end
  end
endmodule // imbf_core_model

// *** verification/imbf_filter_tb.sv ***
// imbf_filter_tb.sv: self-checking bench for the binding filter
// assumes the core model file is compiled before this one
`timescale 1ns/1ps
`include "imbf_consts.svh"
module imbf_filter_tb;
  logic clk, rst, bind_we, bind_is_fe, go_guest;
  logic [2:0] bind_channel, go_pid, ei_ch, fe_ch, pid;
  logic [3:0] fe_req, fe_bg;
  logic [7:0] ei_req;
  logic [47:0] ei_pri;
  logic [5:0] thr, ei_pr;
  logic ei_l, ei_g, ei_b, fl, fg, fb, mode;
  imbf_pkg::imbf_bind_t bind_value, rd;
  int errors, cmp_count;
  // bit 5 host, 4 guest, 3 background, 2:0 channel
  wire [7:0] fe_v = {2'h0, fl, fg, fb, fe_ch};
  wire [7:0] ei_v = {2'h0, ei_l, ei_g, ei_b, ei_ch};

  imbf_core_model u_imbf_core_model (.clk(clk), .rst(rst),
    .go_guest(go_guest), .go_pid(go_pid), .core_guest_mode_flag(mode),
    .core_partition_id(pid));
  imbf_filter u_imbf_filter (.clk(clk), .rst(rst),
    .ei_level_request(ei_req), .ei_priority(ei_pri),
    .fe_level_request(fe_req), .core_guest_mode_flag(mode),
    .core_partition_id(pid), .bind_we(bind_we), .bind_is_fe(bind_is_fe),
    .bind_channel(bind_channel), .bind_value(bind_value),
    .fe_background_enable(fe_bg), .ei_background_priority_threshold(thr),
    .ei_level_request_ff(ei_l), .guest_ei_request_ff(ei_g),
    .background_ei_request_ff(ei_b), .ei_channel_ff(ei_ch),
    .ei_prio_ff(ei_pr), .fe_level_request_ff(fl), .guest_fe_request_ff(fg),
    .background_fe_request_ff(fb), .fe_channel_ff(fe_ch),
    .bind_read_ff(rd));

  // 20 MHz core clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write pulse; the binding register loads it on that edge
  task automatic bnd(input logic fe, input logic [2:0] ch,
                     input logic [3:0] v);
    bind_is_fe = fe;
    bind_channel = ch;
    bind_value = v;
    bind_we = 1'h1;
    tick(1);
    bind_we = 1'h0;
    tick(1); // let an edge pass so back-to-back writes stay distinct
  endtask

  task automatic t_reset();
    chk("ei_out", ei_v, 8'h00);
    chk("ei_prio", {2'h0, ei_pr}, 8'h3f);
    for (int i = 0; i < 12; i++) begin
      bind_is_fe = (i >= 8);
      bind_channel = 3'(i % 8);
      tick(2);
      chk("bind_read", {4'h0, rd}, 8'h00);
    end
  endtask

  task automatic t_fe();
    fe_req = 4'h2;
    tick(3);
    chk("fe_host", fe_v, 8'h21);
    bnd(1'h1, 3'h2, 4'hd);
    fe_req = 4'h4;
    tick(3);
    chk("fe_read", {4'h0, rd}, 8'h0d);
    chk("fe_masked", fe_v, 8'h00);
    go_guest = 1'h1;
    go_pid = 3'h5;
    tick(3);
    chk("fe_guest", fe_v, 8'h12);
    go_pid = 3'h3;
    tick(3);
    chk("fe_bg_off", fe_v, 8'h00);
    fe_bg = 4'h4;
    tick(3);
    chk("fe_bg_on", fe_v, 8'h0a);
    fe_req = 4'h5;
    tick(3);
    chk("fe_host_wins", fe_v, 8'h20);
    fe_req = 4'h0;
  endtask

  task automatic t_ei();
    bnd(1'h0, 3'h4, 4'ha);
    bnd(1'h0, 3'h6, 4'h9);
    go_pid = 3'h2;
    thr = 6'h10;
    ei_pri[24+:6] = 6'h20;
    ei_pri[36+:6] = 6'h08;
    ei_req = 8'h50;
    tick(3);
    chk("ei_bg", ei_v, 8'h0e);
    chk("ei_bg_prio", {2'h0, ei_pr}, 8'h08);
    ei_pri[36+:6] = 6'h10;
    tick(3);
    chk("ei_thr_edge", ei_v, 8'h14);
    ei_pri[36+:6] = 6'h0f;
    tick(3);
    chk("ei_thr_in", ei_v, 8'h0e);
    ei_pri[0+:6] = 6'h3e;
    ei_req = 8'h51;
    tick(3);
    chk("ei_host_wins", ei_v, 8'h20);
    go_guest = 1'h0;
    ei_req = 8'h50;
    tick(3);
    chk("ei_host_mode", ei_v, 8'h00);
  endtask

  // mid-run reset must undo guest bindings made earlier
  task automatic t_rerst();
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    bind_is_fe = 1'h1;
    bind_channel = 3'h2;
    tick(2);
    chk("rerst_read", {4'h0, rd}, 8'h00);
    chk("rerst_ei", ei_v, 8'h26);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence; every wait is a fixed count of cycles
  initial begin
    {rst, bind_we, bind_is_fe, go_guest} = 4'h8;
    {bind_channel, go_pid, bind_value} = 10'h000;
    {fe_req, fe_bg, ei_req, ei_pri} = 64'h0;
    thr = 6'h3f;
    errors = 0;
    cmp_count = 0;
    tick(10);
    rst = 1'h0;
    tick(1);
    t_reset();
    t_fe();
    t_ei();
    t_rerst();
    summarize();
  end
endmodule // imbf_filter_tb

// *** verilog/imbf_classify.sv ***
// imbf_classify.sv: per-channel binding check, purely combinational
// assumes mode and partition are already on the core clock
`timescale 1ns/1ps
`include "imbf_consts.svh"
module imbf_classify (
  input wire logic req,
  input wire imbf_pkg::imbf_bind_t bnd,
  input wire imbf_pkg::imbf_core_t core,
  input wire logic bg_ok,
  output imbf_pkg::imbf_kind_t kind
);
  // binding outcome for one channel
  always_comb begin
    kind = imbf_pkg::IMBF_NONE;
    if (req) begin
      if (!bnd.guest) begin
        kind = imbf_pkg::IMBF_HOST;
      end else if (core.guest_mode) begin
        if (bnd.pid == core.pid) begin
          kind = imbf_pkg::IMBF_GUEST;
        end else if (bg_ok) begin
          kind = imbf_pkg::IMBF_BG;
        end
      end
    end
  end
endmodule // imbf_classify

// *** verilog/imbf_consts.svh ***
// imbf_consts.svh: constants for the interrupt mode binding filter
// assumes inclusion by the package and the design modules
`ifndef IMBF_CONSTS_SVH
`define IMBF_CONSTS_SVH
`define IMBF_NUM_EI 8
`define IMBF_NUM_FE 4
`define IMBF_PID_W 3
`define IMBF_PRIO_W 6
`define IMBF_CH_W 3
`define IMBF_RST_MODE 1'h0
`define IMBF_RST_PID 3'h0
`define IMBF_RST_THRESH 6'h3f
`define IMBF_PRIO_IDLE 6'h3f
`define IMBF_FE_IDX_W 2
`endif

// *** verilog/imbf_filter.sv ***
// imbf_filter.sv: interrupt mode binding filter top
// assumes core mode and partition come from logic on the same clock
//
// How it works
// - each channel bound to host or guest
// - binding holds mode plus partition id
// - host-bound request runs handler in host mode
// - reset binds every channel to host
// - guest-bound request runs handler in guest mode
// - guest binding compares against core partition id
// - fe requests filtered by mode and binding
// - mismatched fe goes background only if enabled
// - ei same; background only above threshold
// - matched and background arbitrated together
// - host-bound requests beat all guest requests
`timescale 1ns/1ps
`include "imbf_consts.svh"
module imbf_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`IMBF_NUM_EI-1:0] ei_level_request,
  input wire logic [`IMBF_NUM_EI*`IMBF_PRIO_W-1:0] ei_priority,
  input wire logic [`IMBF_NUM_FE-1:0] fe_level_request,
  input wire logic core_guest_mode_flag,
  input wire logic [`IMBF_PID_W-1:0] core_partition_id,
  input wire logic bind_we,
  input wire logic bind_is_fe,
  input wire logic [`IMBF_CH_W-1:0] bind_channel,
  input wire imbf_pkg::imbf_bind_t bind_value,
  input wire logic [`IMBF_NUM_FE-1:0] fe_background_enable,
  input wire logic [`IMBF_PRIO_W-1:0] ei_background_priority_threshold,
  output logic ei_level_request_ff,
  output logic guest_ei_request_ff,
  output logic background_ei_request_ff,
  output logic [`IMBF_CH_W-1:0] ei_channel_ff,
  output logic [`IMBF_PRIO_W-1:0] ei_prio_ff,
  output logic fe_level_request_ff,
  output logic guest_fe_request_ff,
  output logic background_fe_request_ff,
  output logic [`IMBF_CH_W-1:0] fe_channel_ff,
  output imbf_pkg::imbf_bind_t bind_read_ff
);
  imbf_pkg::imbf_bind_t ei_channel_binding [`IMBF_NUM_EI];
  imbf_pkg::imbf_bind_t fe_channel_binding [`IMBF_NUM_FE];
  imbf_pkg::imbf_core_t core;
  imbf_pkg::imbf_kind_t ei_kind [`IMBF_NUM_EI];
  imbf_pkg::imbf_kind_t fe_kind [`IMBF_NUM_FE];
  // mode is same-clock logic, so it is read directly each cycle
  assign core = '{guest_mode: core_guest_mode_flag,
                  pid: core_partition_id};

  // binding stores and per-channel classification
  genvar gi;
  generate
    for (gi = 0; gi < `IMBF_NUM_EI; gi++) begin : g_ei
      logic [`IMBF_PRIO_W-1:0] pr;
      logic bg_ok;
      assign pr = ei_priority[gi*`IMBF_PRIO_W +: `IMBF_PRIO_W];
      // lower value is higher priority
      assign bg_ok = pr < ei_background_priority_threshold;
      always_ff @(posedge clk) begin
        if (rst) begin
          ei_channel_binding[gi] <= '{guest: `IMBF_RST_MODE,
                                      pid: `IMBF_RST_PID};
        end else if (bind_we && !bind_is_fe &&
                     bind_channel == (`IMBF_CH_W)'(gi)) begin
          ei_channel_binding[gi] <= bind_value;
        end
      end
      imbf_classify u_cls (
        .req(ei_level_request[gi]),
        .bnd(ei_channel_binding[gi]),
        .core(core),
        .bg_ok(bg_ok),
        .kind(ei_kind[gi])
      );
    end
    for (gi = 0; gi < `IMBF_NUM_FE; gi++) begin : g_fe
      always_ff @(posedge clk) begin
        if (rst) begin
          fe_channel_binding[gi] <= '{guest: `IMBF_RST_MODE,
                                      pid: `IMBF_RST_PID};
        end else if (bind_we && bind_is_fe &&
                     bind_channel == (`IMBF_CH_W)'(gi)) begin
          fe_channel_binding[gi] <= bind_value;
        end
      end
      imbf_classify u_cls (
        .req(fe_level_request[gi]),
        .bnd(fe_channel_binding[gi]),
        .core(core),
        .bg_ok(fe_background_enable[gi]),
        .kind(fe_kind[gi])
      );
    end
  endgenerate

  // ei arbitration: host first, then guest and background as one pool
  imbf_pkg::imbf_kind_t nxt_ei_kind;
  logic [`IMBF_CH_W-1:0] nxt_ei_ch;
  logic [`IMBF_PRIO_W-1:0] nxt_ei_pr;
  logic host_seen;
  always_comb begin
    nxt_ei_kind = imbf_pkg::IMBF_NONE;
    nxt_ei_ch = '0;
    nxt_ei_pr = `IMBF_PRIO_IDLE;
    host_seen = 1'b0;
    for (int i = 0; i < `IMBF_NUM_EI; i++) begin
      if (ei_kind[i] == imbf_pkg::IMBF_HOST) begin
        // host beats guest and background regardless of priority level; among hosts the lowest value wins
        if (!host_seen ||
            ei_priority[i*`IMBF_PRIO_W +: `IMBF_PRIO_W] < nxt_ei_pr) begin
          nxt_ei_kind = imbf_pkg::IMBF_HOST;
          nxt_ei_ch = i[`IMBF_CH_W-1:0];
          nxt_ei_pr = ei_priority[i*`IMBF_PRIO_W +: `IMBF_PRIO_W];
        end
        host_seen = 1'b1;
      end else if (!host_seen && ei_kind[i] != imbf_pkg::IMBF_NONE &&
                   (nxt_ei_kind == imbf_pkg::IMBF_NONE ||
                    ei_priority[i*`IMBF_PRIO_W +: `IMBF_PRIO_W]
                      < nxt_ei_pr)) begin
        nxt_ei_kind = ei_kind[i];
        nxt_ei_ch = i[`IMBF_CH_W-1:0];
        nxt_ei_pr = ei_priority[i*`IMBF_PRIO_W +: `IMBF_PRIO_W];
      end
    end
  end

  // fe arbitration: fixed order, lowest channel first, host first
  imbf_pkg::imbf_kind_t nxt_fe_kind;
  logic [`IMBF_CH_W-1:0] nxt_fe_ch;
  always_comb begin
    nxt_fe_kind = imbf_pkg::IMBF_NONE;
    nxt_fe_ch = '0;
    for (int i = `IMBF_NUM_FE-1; i >= 0; i--) begin
      if (fe_kind[i] != imbf_pkg::IMBF_NONE &&
          nxt_fe_kind != imbf_pkg::IMBF_HOST) begin
        nxt_fe_kind = fe_kind[i];
        nxt_fe_ch = i[`IMBF_CH_W-1:0];
      end
    end
    // a host request anywhere overrides guest picks
    for (int i = `IMBF_NUM_FE-1; i >= 0; i--) begin
      if (fe_kind[i] == imbf_pkg::IMBF_HOST) begin
        nxt_fe_kind = imbf_pkg::IMBF_HOST;
        nxt_fe_ch = i[`IMBF_CH_W-1:0];
      end
    end
  end

  // ei outputs registered: kind picks which line the core sees
  always_ff @(posedge clk) begin
    if (rst) begin
      ei_level_request_ff <= 1'b0;
      guest_ei_request_ff <= 1'b0;
      background_ei_request_ff <= 1'b0;
      ei_channel_ff <= '0;
      ei_prio_ff <= `IMBF_PRIO_IDLE;
    end else begin
      ei_level_request_ff <= nxt_ei_kind == imbf_pkg::IMBF_HOST;
      guest_ei_request_ff <= nxt_ei_kind == imbf_pkg::IMBF_GUEST;
      background_ei_request_ff <= nxt_ei_kind == imbf_pkg::IMBF_BG;
      ei_channel_ff <= nxt_ei_ch;
      ei_prio_ff <= nxt_ei_pr;
    end
  end

  // fe outputs registered
  always_ff @(posedge clk) begin
    if (rst) begin
      fe_level_request_ff <= 1'b0;
      guest_fe_request_ff <= 1'b0;
      background_fe_request_ff <= 1'b0;
      fe_channel_ff <= '0;
    end else begin
      fe_level_request_ff <= nxt_fe_kind == imbf_pkg::IMBF_HOST;
      guest_fe_request_ff <= nxt_fe_kind == imbf_pkg::IMBF_GUEST;
      background_fe_request_ff <= nxt_fe_kind == imbf_pkg::IMBF_BG;
      fe_channel_ff <= nxt_fe_ch;
    end
  end

  // binding readback of the addressed channel, one cycle late
  always_ff @(posedge clk) begin
    if (rst) begin
      bind_read_ff <= '0;
    end else if (bind_is_fe) begin
      bind_read_ff <= fe_channel_binding[bind_channel[`IMBF_FE_IDX_W-1:0]];
    end else begin
      bind_read_ff <= ei_channel_binding[bind_channel];
    end
  end

  // checks
  sequence s_host_fe_now;
    fe_kind[0] == imbf_pkg::IMBF_HOST;
  endsequence
  a_host_fe_wins: assert property (@(posedge clk) disable iff (rst)
    s_host_fe_now |=> fe_level_request_ff)
    else $error("host fe request not presented");
  a_host_ei_wins: assert property (@(posedge clk) disable iff (rst)
    (ei_kind[0] == imbf_pkg::IMBF_HOST) |=> ei_level_request_ff
      && !guest_ei_request_ff)
    else $error("host ei request not preferred");
  a_host_mode_guest: assert property (@(posedge clk) disable iff (rst)
    !core_guest_mode_flag |=> !guest_ei_request_ff
      && !background_ei_request_ff)
    else $error("guest ei presented in host mode");
  a_host_mode_fe: assert property (@(posedge clk) disable iff (rst)
    !core_guest_mode_flag |=> !guest_fe_request_ff
      && !background_fe_request_ff)
    else $error("guest fe presented in host mode");
  a_bg_fe_enable: assert property (@(posedge clk) disable iff (rst)
    background_fe_request_ff |->
      $past(fe_background_enable[nxt_fe_ch[`IMBF_FE_IDX_W-1:0]]))
    else $error("background fe without enable");
  a_bg_ei_thresh: assert property (@(posedge clk) disable iff (rst)
    background_ei_request_ff |->
      ei_prio_ff < $past(ei_background_priority_threshold))
    else $error("background ei not above threshold");
  a_one_hot_ei: assert property (@(posedge clk) disable iff (rst)
    $onehot0({ei_level_request_ff, guest_ei_request_ff,
              background_ei_request_ff}))
    else $error("several ei kinds at once");
  a_reset_host: assert property (@(posedge clk)
    rst |=> !ei_channel_binding[0].guest
      && !fe_channel_binding[0].guest)
    else $error("binding not host after reset");
  a_guest_match: assert property (@(posedge clk) disable iff (rst)
    guest_fe_request_ff |-> $past(core_guest_mode_flag)
      && $past(fe_channel_binding[nxt_fe_ch[`IMBF_FE_IDX_W-1:0]].pid)
         == $past(core_partition_id))
    else $error("guest fe with partition mismatch");
endmodule // imbf_filter

// *** verilog/imbf_pkg.sv ***
// imbf_pkg.sv: types shared by the interrupt mode binding filter
// assumes imbf_consts.svh sits beside it on the include path
`include "imbf_consts.svh"
package imbf_pkg;
  // binding of one channel; partition only counts in guest mode
  typedef struct packed {
    logic guest;
    logic [`IMBF_PID_W-1:0] pid;
  } imbf_bind_t;
  // kind of request presented to the core
  typedef enum logic [3:0] {
    IMBF_NONE = 4'h1,
    IMBF_HOST = 4'h2,
    IMBF_GUEST = 4'h4,
    IMBF_BG = 4'h8
  } imbf_kind_t;
  // mode reported by the core
  typedef struct packed {
    logic guest_mode;
    logic [`IMBF_PID_W-1:0] pid;
  } imbf_core_t;
endpackage
